// file: inc/perf_consts.svh
// Constants for the performance event monitor
// Overview of operation
// - Four independent 32-bit counters, each counting a software-selected event.
// - Events include clocks, cache misses, dispatch types, mispredicted branches.
// - Control registers pick events, enable overflow interrupts and gate counting.
// - A counter with its top bit set is overflowed and can trigger interrupt.
// - A selected time-base bit rising from zero to one can trigger interrupt.
// - Condition may be raised anytime; exception taken only with external enable set.
// - The taken exception vectors to offset 0x00F00.
// - Priority is below external interrupt and above decrementer interrupt.
// - Overflow trigger stores the overflowing instruction address as sampled address.
// - Time-base trigger stores last completed instruction address as sampled address.
// - Counters, controls and sampled address are writable only at supervisor level.
// - User read-only views return counters, controls and sampled address.
// - Hardware clears the interrupt enable bit whenever the interrupt is signalled.
// - Freeze bit in first control stops every hardware counter change.
// - First control clears at reset and reads leave it unchanged.
`ifndef PERF_CONSTS_SVH
`define PERF_CONSTS_SVH

`define PM_NUM_CNT 4
`define PM_MSB 31
`define PM_ONE 32'h00000001
`define PM_WORD_ZERO 32'h00000000
`define PM_VECTOR 20'h00F00
`define PM_EV_W 4
`define PM_EVIN_W 16
`define PM_TB_W 4

// Register addresses
`define PM_A_CTL0 10'h3B8
`define PM_A_CNT1 10'h3B9
`define PM_A_CNT2 10'h3BA
`define PM_A_SAMP 10'h3BB
`define PM_A_CTL1 10'h3BC
`define PM_A_CNT3 10'h3BD
`define PM_A_CNT4 10'h3BE
`define PM_A_UCTL0 10'h3A8
`define PM_A_UCNT1 10'h3A9
`define PM_A_UCNT2 10'h3AA
`define PM_A_USAMP 10'h3AB
`define PM_A_UCTL1 10'h3AC
`define PM_A_UCNT3 10'h3AD
`define PM_A_UCNT4 10'h3AE
`define PM_A_STATUS 10'h3C0
`define PM_A_MASK 10'h3C1

// First control fields
`define PM_FREEZE 31
`define PM_NO_SUP 30
`define PM_NO_USER 29
`define PM_NO_MARK 28
`define PM_NO_UNMARK 27
`define PM_IRQ_EN 26
`define PM_STOP_ON_IRQ 25
`define PM_TB_SEL_HI 24
`define PM_TB_SEL_LO 23
`define PM_TB_EN 22
`define PM_OVF1_EN 21
`define PM_OVFN_EN 20
`define PM_EV1_HI 15
`define PM_EV1_LO 12
`define PM_EV2_HI 11
`define PM_EV2_LO 8
// Second control fields
`define PM_EV3_HI 31
`define PM_EV3_LO 28
`define PM_EV4_HI 27
`define PM_EV4_LO 24

// Interrupt status bits
`define PM_IRQ_W 3
`define PM_ST_OVF 0
`define PM_ST_TB 1
`define PM_ST_REJECT 2

`endif

// file: inc/perf_pkg.sv
// Types for the performance event monitor
package perf_pkg;
    typedef logic [31:0] word_t;
    typedef logic [9:0] addr_t;
    typedef enum logic [3:0] {
        EV_NONE,
        EV_CLOCK,
        EV_ICACHE_MISS,
        EV_DCACHE_MISS,
        EV_L2_MISS,
        EV_DISP_INT,
        EV_DISP_LDST,
        EV_DISP_FLOAT,
        EV_DISP_BRANCH,
        EV_BRANCH_MISPRED
    } event_sel_t;
endpackage

// file: design/event_counter_cell.sv
// One 32-bit event counter with software load
`timescale 1ns/1ps
`include "perf_consts.svh"
module event_counter_cell (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic countEn,
    input wire logic eventHit,
    input wire logic loadEn,
    input wire perf_pkg::word_t loadData,
    output perf_pkg::word_t count
);
    import perf_pkg::*;

    word_t next_count;

    // Software load wins over counting
    always_comb begin
        next_count = count;
        if (loadEn) begin
            next_count = loadData;
        end else if (countEn && eventHit) begin
            next_count = count + `PM_ONE;
        end
    end

    // Counter register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= `PM_WORD_ZERO;
        end else if (ce) begin
            count <= next_count;
        end
    end

    a_count_step: assert property (
        @(posedge clk) disable iff (rst)
        ce && countEn && eventHit && !loadEn |=> count == $past(count) + `PM_ONE)
        else $error("counter did not step by one");
endmodule

// file: design/perf_irq_status.sv
// Sticky interrupt status with mask and level output
`timescale 1ns/1ps
`include "perf_consts.svh"
module perf_irq_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`PM_IRQ_W-1:0] setEvents,
    input wire logic clrWr,
    input wire logic maskWr,
    input wire perf_pkg::word_t wrData,
    output logic [`PM_IRQ_W-1:0] status,
    output logic [`PM_IRQ_W-1:0] mask,
    output logic irq
);
    import perf_pkg::*;

    logic [`PM_IRQ_W-1:0] next_status;
    logic [`PM_IRQ_W-1:0] next_mask;
    logic [`PM_IRQ_W-1:0] clrBits;

    // Write one to clear, new events win
    always_comb begin
        clrBits = clrWr ? wrData[`PM_IRQ_W-1:0] : {`PM_IRQ_W{1'b0}};
        next_status = (status & ~clrBits) | setEvents;
        next_mask = maskWr ? wrData[`PM_IRQ_W-1:0] : mask;
    end

    // Status and mask registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= {`PM_IRQ_W{1'b0}};
            mask <= {`PM_IRQ_W{1'b0}};
        end else if (ce) begin
            status <= next_status;
            mask <= next_mask;
        end
    end

    // Level interrupt
    assign irq = |(status & mask);

    a_set_wins: assert property (
        @(posedge clk) disable iff (rst)
        ce && (|setEvents) |=> (status & $past(setEvents)) == $past(setEvents))
        else $error("status event lost");
endmodule

// file: design/perf_event_monitor.sv
// Performance event monitor: counters, controls, sampled address, exception
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "perf_consts.svh"
module perf_event_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire perf_pkg::addr_t regAddr,
    input wire perf_pkg::word_t regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic supervisorMode,
    input wire logic procUserMode,
    input wire logic procMarked,
    input wire logic [`PM_EVIN_W-1:0] eventIn,
    input wire logic [`PM_TB_W-1:0] timeBaseBits,
    input wire perf_pkg::word_t thresholdAddr,
    input wire perf_pkg::word_t lastCompletedAddr,
    input wire logic externalIrqEnable,
    input wire logic extIrqPending,
    output perf_pkg::word_t regRdData,
    output logic pmCondition,
    output logic excTaken,
    output logic [19:0] excVector,
    output logic decHold,
    output logic irq
);
    import perf_pkg::*;

    localparam addr_t CNT_ADDR [`PM_NUM_CNT] = '{
        `PM_A_CNT1, `PM_A_CNT2, `PM_A_CNT3, `PM_A_CNT4
    };

    word_t ctlFirst;
    word_t next_ctlFirst;
    word_t ctlSecond;
    word_t next_ctlSecond;
    word_t sampledInstrAddr;
    word_t next_sampledInstrAddr;
    word_t next_regRdData;
    word_t cnt [`PM_NUM_CNT];
    logic [`PM_EV_W-1:0] evSel [`PM_NUM_CNT];
    logic [`PM_NUM_CNT-1:0] evHit;
    logic [`PM_NUM_CNT-1:0] cntLoad;
    logic stopAfterIrq;
    logic next_stopAfterIrq;
    logic next_pmCondition;
    logic [`PM_TB_W-1:0] tbPrev;
    logic [`PM_TB_W-1:0] next_tbPrev;
    logic tbWas;
    logic wrOk;
    logic wrReject;
    logic mapped;
    logic countOk;
    logic ovfCond;
    logic tbBit;
    logic tbRise;
    logic pmSignal;
    logic takeNow;
    logic [`PM_IRQ_W-1:0] stEvents;
    logic [`PM_IRQ_W-1:0] stStatus;
    logic [`PM_IRQ_W-1:0] stMask;
    word_t rdValue;
    logic rdUserView;

    // Event select of a counter to a hit
    function automatic logic eventHitOf(input logic [`PM_EV_W-1:0] sel,
                                        input logic [`PM_EVIN_W-1:0] ev);
        eventHitOf = (sel == EV_CLOCK) || ((sel != EV_NONE) && ev[sel]);
    endfunction

    // Address and privilege decode
    always_comb begin
        case (regAddr)
            `PM_A_CTL0, `PM_A_CTL1, `PM_A_SAMP, `PM_A_CNT1, `PM_A_CNT2,
            `PM_A_CNT3, `PM_A_CNT4, `PM_A_STATUS, `PM_A_MASK: begin
                mapped = 1'b1;
            end
            `PM_A_UCTL0, `PM_A_UCTL1, `PM_A_USAMP, `PM_A_UCNT1, `PM_A_UCNT2,
            `PM_A_UCNT3, `PM_A_UCNT4: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        wrOk = regWr && supervisorMode;
        wrReject = regWr && !supervisorMode && mapped;
    end

    // Event selects and counting permission
    always_comb begin
        evSel[0] = ctlFirst[`PM_EV1_HI:`PM_EV1_LO];
        evSel[1] = ctlFirst[`PM_EV2_HI:`PM_EV2_LO];
        evSel[2] = ctlSecond[`PM_EV3_HI:`PM_EV3_LO];
        evSel[3] = ctlSecond[`PM_EV4_HI:`PM_EV4_LO];
        countOk = !ctlFirst[`PM_FREEZE]
            && !(ctlFirst[`PM_NO_SUP] && !procUserMode)
            && !(ctlFirst[`PM_NO_USER] && procUserMode)
            && !(ctlFirst[`PM_NO_MARK] && procMarked)
            && !(ctlFirst[`PM_NO_UNMARK] && !procMarked)
            && !stopAfterIrq;
    end

    // Four counters
    for (genvar i = 0; i < `PM_NUM_CNT; i++) begin : g_cnt
        assign evHit[i] = eventHitOf(evSel[i], eventIn);
        assign cntLoad[i] = wrOk && (regAddr == CNT_ADDR[i]);
        event_counter_cell u_cell (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .countEn(countOk),
            .eventHit(evHit[i]),
            .loadEn(cntLoad[i]),
            .loadData(regWrData),
            .count(cnt[i])
        );
    end

    // Interrupt sources
    always_comb begin
        ovfCond = (ctlFirst[`PM_OVF1_EN] && cnt[0][`PM_MSB])
            || (ctlFirst[`PM_OVFN_EN]
                && (cnt[1][`PM_MSB] || cnt[2][`PM_MSB] || cnt[3][`PM_MSB]));
        tbBit = timeBaseBits[ctlFirst[`PM_TB_SEL_HI:`PM_TB_SEL_LO]];
        // Edge taken on the selected bit itself, so a new select makes no false rise
        tbWas = tbPrev[ctlFirst[`PM_TB_SEL_HI:`PM_TB_SEL_LO]];
        tbRise = ctlFirst[`PM_TB_EN] && tbBit && !tbWas;
        pmSignal = ce && ctlFirst[`PM_IRQ_EN] && (ovfCond || tbRise);
    end

    // Control, sampled address and pending state
    always_comb begin
        next_ctlFirst = ctlFirst;
        next_ctlSecond = ctlSecond;
        next_sampledInstrAddr = sampledInstrAddr;
        next_stopAfterIrq = stopAfterIrq;
        next_pmCondition = pmCondition;
        next_tbPrev = timeBaseBits;
        if (wrOk && regAddr == `PM_A_CTL0) begin
            next_ctlFirst = regWrData;
            next_stopAfterIrq = 1'b0;
        end
        if (wrOk && regAddr == `PM_A_CTL1) begin
            next_ctlSecond = regWrData;
        end
        if (wrOk && regAddr == `PM_A_SAMP) begin
            next_sampledInstrAddr = regWrData;
        end
        if (takeNow) begin
            next_pmCondition = 1'b0;
        end
        if (pmSignal) begin
            next_ctlFirst[`PM_IRQ_EN] = 1'b0;
            next_pmCondition = 1'b1;
            if (ctlFirst[`PM_STOP_ON_IRQ]) begin
                next_stopAfterIrq = 1'b1;
            end
            if (ovfCond) begin
                next_sampledInstrAddr = thresholdAddr;
            end else begin
                next_sampledInstrAddr = lastCompletedAddr;
            end
        end
    end

    // Control registers cleared at reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctlFirst <= `PM_WORD_ZERO;
            ctlSecond <= `PM_WORD_ZERO;
            sampledInstrAddr <= `PM_WORD_ZERO;
            stopAfterIrq <= 1'b0;
            pmCondition <= 1'b0;
            tbPrev <= {`PM_TB_W{1'b0}};
        end else if (ce) begin
            ctlFirst <= next_ctlFirst;
            ctlSecond <= next_ctlSecond;
            sampledInstrAddr <= next_sampledInstrAddr;
            stopAfterIrq <= next_stopAfterIrq;
            pmCondition <= next_pmCondition;
            tbPrev <= next_tbPrev;
        end
    end

    // Exception acceptance and priority
    always_comb begin
        takeNow = ce && pmCondition && externalIrqEnable
            && !extIrqPending;
        excTaken = takeNow;
        decHold = pmCondition && externalIrqEnable;
        excVector = `PM_VECTOR;
    end

    // Sticky status of block events
    always_comb begin
        stEvents = {`PM_IRQ_W{1'b0}};
        stEvents[`PM_ST_OVF] = pmSignal && ovfCond;
        stEvents[`PM_ST_TB] = pmSignal && !ovfCond;
        stEvents[`PM_ST_REJECT] = ce && wrReject;
    end

    perf_irq_status u_status (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .setEvents(stEvents),
        .clrWr(wrOk && regAddr == `PM_A_STATUS),
        .maskWr(wrOk && regAddr == `PM_A_MASK),
        .wrData(regWrData),
        .status(stStatus),
        .mask(stMask),
        .irq(irq)
    );

    // Read mux; user views open to all, the rest to supervisor
    always_comb begin
        rdValue = `PM_WORD_ZERO;
        rdUserView = 1'b0;
        case (regAddr)
            `PM_A_UCTL0: begin rdValue = ctlFirst; rdUserView = 1'b1; end
            `PM_A_UCTL1: begin rdValue = ctlSecond; rdUserView = 1'b1; end
            `PM_A_USAMP: begin rdValue = sampledInstrAddr; rdUserView = 1'b1; end
            `PM_A_UCNT1: begin rdValue = cnt[0]; rdUserView = 1'b1; end
            `PM_A_UCNT2: begin rdValue = cnt[1]; rdUserView = 1'b1; end
            `PM_A_UCNT3: begin rdValue = cnt[2]; rdUserView = 1'b1; end
            `PM_A_UCNT4: begin rdValue = cnt[3]; rdUserView = 1'b1; end
            `PM_A_CTL0: begin rdValue = ctlFirst; end
            `PM_A_CTL1: begin rdValue = ctlSecond; end
            `PM_A_SAMP: begin rdValue = sampledInstrAddr; end
            `PM_A_CNT1: begin rdValue = cnt[0]; end
            `PM_A_CNT2: begin rdValue = cnt[1]; end
            `PM_A_CNT3: begin rdValue = cnt[2]; end
            `PM_A_CNT4: begin rdValue = cnt[3]; end
            `PM_A_STATUS: begin rdValue = {29'h00000000, stStatus}; end
            `PM_A_MASK: begin rdValue = {29'h00000000, stMask}; end
            default: begin rdValue = `PM_WORD_ZERO; end
        endcase
        next_regRdData = `PM_WORD_ZERO;
        if (regRd && (supervisorMode || rdUserView)) begin
            next_regRdData = rdValue;
        end
    end

    // Read data for one cycle only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= `PM_WORD_ZERO;
        end else if (ce) begin
            regRdData <= next_regRdData;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ovf_signal;
        pmSignal && ovfCond;
    endsequence

    sequence s_tb_signal;
        pmSignal && !ovfCond;
    endsequence

    a_freeze_holds: assert property (
        ce && ctlFirst[`PM_FREEZE] && !cntLoad[0] |=> $stable(cnt[0]))
        else $error("frozen counter changed");

    a_clock_count: assert property (
        ce && countOk && evSel[0] == EV_CLOCK && !cntLoad[0]
        |=> cnt[0] == $past(cnt[0]) + `PM_ONE)
        else $error("clock event not counted");

    a_msb_signal: assert property (
        ce && ctlFirst[`PM_IRQ_EN] && ctlFirst[`PM_OVF1_EN] && cnt[0][`PM_MSB] |-> pmSignal)
        else $error("overflow did not signal");

    a_tb_signal: assert property (
        ce && ctlFirst[`PM_IRQ_EN] && ctlFirst[`PM_TB_EN] && tbBit && !tbWas |-> pmSignal)
        else $error("time base rise did not signal");

    a_irq_disarm: assert property (
        pmSignal |=> !ctlFirst[`PM_IRQ_EN] && pmCondition)
        else $error("signal enable not cleared");

    a_take_needs_ee: assert property (
        excTaken |-> externalIrqEnable && pmCondition ##1 (!pmCondition || $past(pmSignal)))
        else $error("exception taken without enable");

    a_vector_fixed: assert property (
        excTaken |-> excVector == `PM_VECTOR)
        else $error("wrong exception vector");

    a_prio_order: assert property (
        ce && pmCondition && externalIrqEnable |-> decHold && (excTaken == !extIrqPending))
        else $error("exception priority broken");

    a_ovf_capture: assert property (
        s_ovf_signal |=> sampledInstrAddr == $past(thresholdAddr))
        else $error("overflow address not sampled");

    a_tb_capture: assert property (
        s_tb_signal |=> sampledInstrAddr == $past(lastCompletedAddr))
        else $error("completed address not sampled");

    a_user_reject: assert property (
        ce && regWr && !supervisorMode |=> $stable(ctlSecond))
        else $error("user write accepted");

    a_user_view: assert property (
        ce && regRd && regAddr == `PM_A_UCTL1 |=> regRdData == $past(ctlSecond))
        else $error("user view mismatch");

    a_read_no_effect: assert property (
        ce && regRd && !regWr && !pmSignal |=> $stable(ctlFirst))
        else $error("read changed first control");
endmodule

// file: dv/core_model.sv
// Core-side stand-in: event pulses, time base, instruction addresses, modes
`timescale 1ns/1ps
`include "perf_consts.svh"
module core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire perf_pkg::word_t rnd,
    output logic [`PM_EVIN_W-1:0] eventIn,
    output logic [`PM_TB_W-1:0] timeBaseBits,
    output perf_pkg::word_t thresholdAddr,
    output perf_pkg::word_t lastCompletedAddr,
    output logic procUserMode,
    output logic procMarked
);
    import perf_pkg::*;
    logic [7:0] tbCount;
    // Events only while the core runs, so idle periods leave counters still, except those selecting the clock event
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            eventIn <= 16'h0000;
            tbCount <= 8'h00;
            thresholdAddr <= 32'h00000000;
            lastCompletedAddr <= 32'h00000000;
            procUserMode <= 1'b0;
            procMarked <= 1'b0;
        end else begin
            eventIn <= run ? rnd[15:0] : 16'h0000;
            tbCount <= run ? tbCount + 8'h01 : tbCount;
            thresholdAddr <= {rnd[31:2], 2'b00};
            lastCompletedAddr <= {rnd[31:2], 2'b00} + 32'h00000004;
            procUserMode <= rnd[16];
            procMarked <= rnd[17];
        end
    end
    // Upper time-base bits rise slowly enough to be seen one at a time
    assign timeBaseBits = tbCount[7:4];
endmodule

// file: dv/tb.sv
// Self-checking bench for the performance event monitor
`timescale 1ns/1ps
`include "perf_consts.svh"
module tb;
    import perf_pkg::*;
    logic clk, rst, ce, regWr, regRd, supervisorMode, run;
    logic externalIrqEnable, extIrqPending, procUserMode, procMarked;
    addr_t regAddr;
    word_t regWrData, regRdData, thresholdAddr, lastCompletedAddr, rnd;
    logic [`PM_EVIN_W-1:0] eventIn;
    logic [`PM_TB_W-1:0] timeBaseBits;
    logic pmCondition, excTaken, decHold, irq;
    logic [19:0] excVector;
    integer seed = 75910;
    integer err_count = 0;
    integer samples_checked = 0;
    word_t mCtl0, mCtl1, mSamp, rdExp, nextCtl0;
    word_t mCnt [4];
    logic [2:0] mSt, mMk, setSt;
    logic [3:0] prevTb, sel [4];
    logic mPend, ok, ovf, tbr, sig, wrOk, mStop;
    addr_t cntAddr [4] = '{`PM_A_CNT1, `PM_A_CNT2, `PM_A_CNT3, `PM_A_CNT4};

    perf_event_monitor perf_event_monitor_inst (.clk(clk), .rst(rst), .ce(ce),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .supervisorMode(supervisorMode), .procUserMode(procUserMode),
        .procMarked(procMarked), .eventIn(eventIn), .timeBaseBits(timeBaseBits),
        .thresholdAddr(thresholdAddr), .lastCompletedAddr(lastCompletedAddr),
        .externalIrqEnable(externalIrqEnable), .extIrqPending(extIrqPending),
        .regRdData(regRdData), .pmCondition(pmCondition), .excTaken(excTaken),
        .excVector(excVector), .decHold(decHold), .irq(irq));
    core_model core_model_inst (.clk(clk), .rst(rst), .run(run), .rnd(rnd),
        .eventIn(eventIn), .timeBaseBits(timeBaseBits), .thresholdAddr(thresholdAddr),
        .lastCompletedAddr(lastCompletedAddr), .procUserMode(procUserMode),
        .procMarked(procMarked));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) rnd <= $random(seed);

    function automatic logic mapped(addr_t a);
        return (a >= 10'h3A8 && a <= 10'h3AE) || (a >= 10'h3B8 && a <= 10'h3C1 && a != 10'h3BF);
    endfunction
    function automatic logic hit(logic [3:0] s);
        return (s == 4'h0) ? 1'b0 : ((s == 4'h1) ? 1'b1 : eventIn[s]);
    endfunction
    // Reference read: user views alias the supervisor ones, user blocked elsewhere
    function automatic word_t regVal(addr_t a, logic sup);
        addr_t s;
        s = (a >= 10'h3A8 && a <= 10'h3AE) ? a + 10'h010 : a;
        if (!sup && s == a) return 32'h00000000;
        case (s)
            `PM_A_CTL0: return mCtl0;
            `PM_A_CNT1: return mCnt[0];
            `PM_A_CNT2: return mCnt[1];
            `PM_A_SAMP: return mSamp;
            `PM_A_CTL1: return mCtl1;
            `PM_A_CNT3: return mCnt[2];
            `PM_A_CNT4: return mCnt[3];
            `PM_A_STATUS: return {29'h00000000, mSt};
            `PM_A_MASK: return {29'h00000000, mMk};
            default: return 32'h00000000;
        endcase
    endfunction

    // Reference gating, trigger and control-register next value
    always_comb begin
        sel[0] = mCtl0[15:12];
        sel[1] = mCtl0[11:8];
        sel[2] = mCtl1[31:28];
        sel[3] = mCtl1[27:24];
        ok = !mCtl0[31] && !(mCtl0[30] && !procUserMode) && !(mCtl0[29] && procUserMode)
            && !(mCtl0[28] && procMarked) && !(mCtl0[27] && !procMarked) && !mStop;
        ovf = (mCtl0[21] && mCnt[0][31])
            || (mCtl0[20] && (mCnt[1][31] || mCnt[2][31] || mCnt[3][31]));
        tbr = mCtl0[22] && timeBaseBits[mCtl0[24:23]] && !prevTb[mCtl0[24:23]];
        sig = mCtl0[26] && (ovf || tbr);
        wrOk = regWr && supervisorMode;
        nextCtl0 = (wrOk && regAddr == `PM_A_CTL0) ? regWrData : mCtl0;
        if (sig) nextCtl0[26] = 1'b0;
        setSt = {regWr && !supervisorMode && mapped(regAddr), sig && !ovf, sig && ovf};
    end

    // Reference registers, counters and pending exception
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mCtl0 <= 32'h00000000;
            mCtl1 <= 32'h00000000;
            mSamp <= 32'h00000000;
            rdExp <= 32'h00000000;
            mSt <= 3'h0;
            mMk <= 3'h0;
            mPend <= 1'b0;
            mStop <= 1'b0;
            prevTb <= 4'h0;
            for (int i = 0; i < 4; i++) mCnt[i] <= 32'h00000000;
        end else if (ce) begin
            rdExp <= regRd ? regVal(regAddr, supervisorMode) : 32'h00000000;
            mCtl0 <= nextCtl0;
            if (wrOk && regAddr == `PM_A_CTL1) mCtl1 <= regWrData;
            for (int i = 0; i < 4; i++) begin
                if (wrOk && regAddr == cntAddr[i]) mCnt[i] <= regWrData;
                else if (ok && hit(sel[i])) mCnt[i] <= mCnt[i] + 32'h00000001;
            end
            if (sig) mSamp <= ovf ? thresholdAddr : lastCompletedAddr;
            else if (wrOk && regAddr == `PM_A_SAMP) mSamp <= regWrData;
            mSt <= (mSt & ~((wrOk && regAddr == `PM_A_STATUS) ? regWrData[2:0] : 3'h0)) | setSt;
            if (wrOk && regAddr == `PM_A_MASK) mMk <= regWrData[2:0];
            mPend <= sig || (mPend && !(externalIrqEnable && !extIrqPending));
            mStop <= (sig && mCtl0[25]) || (mStop && !(wrOk && regAddr == `PM_A_CTL0));
            prevTb <= timeBaseBits;
        end
    end

    task automatic check(string nm, word_t seen, word_t exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Outputs against the reference once settled in every cycle
    always @(negedge clk) begin
        if (!rst) begin
            check("regRdData", regRdData, rdExp);
            check("pmCondition", pmCondition, mPend);
            check("excTaken", excTaken,
                mPend && externalIrqEnable && !extIrqPending && ce);
            check("decHold", decHold, mPend && externalIrqEnable);
            check("irq", irq, |(mSt & mMk));
            check("excVector", excVector, 20'h00F00);
        end
    end

    task automatic wr(addr_t a, word_t d, logic s = 1'b1);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        supervisorMode <= s;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(addr_t a, logic s = 1'b1);
        @(posedge clk);
        regAddr <= a;
        supervisorMode <= s;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic rdChk(addr_t a, word_t exp);
        rd(a);
        @(negedge clk);
        check("readback", regRdData, exp);
    endtask
    task automatic waitPm();
        int n;
        n = 0;
        while (pmCondition !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            err_count++;
            stop_test();
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 10'h000;
        regWrData = 32'h00000000;
        supervisorMode = 1'b1;
        run = 1'b0;
        externalIrqEnable = 1'b0;
        extIrqPending = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // Reset contents, then every address from 0x3A8 to 0x3C2, mapped or not
        rdChk(`PM_A_CTL0, 32'h00000000);
        for (int a = 10'h3A8; a <= 10'h3C2; a++) rd(addr_t'(a));
        // Frozen load of every counter, control and sampled address, read through both views and both modes
        wr(`PM_A_CTL0, 32'h80000000);
        for (int i = 0; i < 4; i++) wr(cntAddr[i], $random(seed));
        wr(`PM_A_CTL1, $random(seed));
        wr(`PM_A_SAMP, $random(seed));
        wr(`PM_A_UCNT1, 32'h0BADF00D);
        for (int a = 10'h3A8; a <= 10'h3BE; a++) begin
            rd(addr_t'(a), 1'b1);
            rd(addr_t'(a), 1'b0);
        end
        // Refused user write flagged, masked level, then cleared
        wr(`PM_A_CNT1, 32'h12345678, 1'b0);
        rdChk(`PM_A_STATUS, 32'h00000004);
        wr(`PM_A_MASK, 32'h00000007);
        wr(`PM_A_MASK, 32'h00000000);
        wr(`PM_A_MASK, 32'h00000007);
        wr(`PM_A_STATUS, 32'h00000004);
        rd(`PM_A_CNT1);
        // Every event code on counters two to four, clock on counter one, user-mode counting barred
        run <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            wr(`PM_A_CTL0, 32'h20001000 | (word_t'(c) << 8));
            wr(`PM_A_CTL1, (word_t'(c) << 28) | (word_t'(15 - c) << 24));
            ce <= c[0];
            repeat (8) @(posedge clk);
            ce <= 1'b1;
            for (int i = 0; i < 4; i++) rd(cntAddr[i]);
        end
        wr(`PM_A_CTL0, 32'h80001100);
        repeat (20) @(posedge clk);
        for (int i = 0; i < 4; i++) rd(cntAddr[i]);
        // Overflow held while disabled, then behind an external request
        wr(`PM_A_CNT1, 32'h7FFFFFF0);
        wr(`PM_A_CTL0, 32'h04201000);
        waitPm();
        repeat (5) @(posedge clk);
        extIrqPending <= 1'b1;
        externalIrqEnable <= 1'b1;
        repeat (5) @(posedge clk);
        extIrqPending <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        check("pmCondition", pmCondition, 1'b0);
        rdChk(`PM_A_CTL0, 32'h00201000);
        rdChk(`PM_A_STATUS, 32'h00000001);
        rd(`PM_A_SAMP);
        wr(`PM_A_CTL0, 32'h06201000);
        repeat (4) @(posedge clk);
        rdChk(`PM_A_CTL0, 32'h02201000);
        rd(`PM_A_CNT1);
        rd(`PM_A_SAMP);
        // Time-base rise on a selected bit with counters frozen
        externalIrqEnable <= 1'b0;
        wr(`PM_A_STATUS, 32'h00000003);
        wr(`PM_A_CTL0, 32'h85400000);
        waitPm();
        rdChk(`PM_A_STATUS, 32'h00000002);
        rd(`PM_A_SAMP);
        externalIrqEnable <= 1'b1;
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
